// File: lcd_cmd_pkg.sv
package lcd_cmd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Command codes
    localparam logic [7:0] CMD_SCREEN_OFF     = 8'h58;
    localparam logic [7:0] CMD_SCREEN_ON      = 8'h59;
    localparam logic [7:0] CMD_LAYER_COMBINE  = 8'h5b;
    localparam logic [7:0] CMD_CURSOR_LOAD    = 8'h46;
    localparam logic [7:0] CMD_CURSOR_SHAPE   = 8'h5d;
    localparam logic [7:0] CMD_MEMORY_STORE   = 8'h42;
    localparam logic [7:0] CMD_STEP_BASE      = 8'h4c;
    localparam logic [7:0] CMD_STEP_MASK      = 8'hfc;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] REG_DISPLAY_ENABLE        = 8'h09;
    localparam logic [7:0] REG_BLOCK_ATTRIBUTE_FLASH = 8'h0a;
    localparam logic [7:0] REG_CURSOR_WIDTH_CFG      = 8'h15;
    localparam logic [7:0] REG_CURSOR_HEIGHT_STYLE   = 8'h16;
    localparam logic [7:0] REG_CURSOR_STEP_SETTING   = 8'h17;
    localparam logic [7:0] REG_LAYER_COMBINE_CFG     = 8'h18;
    localparam logic [7:0] REG_CURSOR_ADDR_LOW       = 8'h1c;
    localparam logic [7:0] REG_CURSOR_ADDR_HIGH      = 8'h1d;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int SCREEN_ON_BIT          = 0;
    localparam int FLASH_RATE_LSB         = 0;
    localparam int FIRST_ATTR_LSB         = 2;
    localparam int SECOND_FOURTH_ATTR_LSB = 4;
    localparam int THIRD_ATTR_LSB         = 6;
    localparam int COMBINE_METHOD_LSB     = 0;
    localparam int FIRST_TEXT_BIT         = 2;
    localparam int THIRD_TEXT_BIT         = 3;
    localparam int CURSOR_SIZE_MSB        = 3;
    localparam int CURSOR_STYLE_BIT       = 7;

    // Step direction codes, taken from the low two bits of the command
    localparam logic [1:0] STEP_RIGHT = 2'h0;
    localparam logic [1:0] STEP_LEFT  = 2'h1;
    localparam logic [1:0] STEP_UP    = 2'h2;
    localparam logic [1:0] STEP_DOWN  = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0]  RST_REG_BYTE    = 8'h00;
    localparam logic [15:0] RST_CURSOR_ADDR = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef struct packed {
        logic       is_cmd;
        logic [7:0] data;
    } host_req_s;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
    } mem_word_s;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SCREEN_ENABLE,
        ST_LAYER_COMBINE,
        ST_CURSOR_LOAD,
        ST_CURSOR_SHAPE,
        ST_MEMORY_STORE
    } cmd_state_e;

endpackage

// File: lcd_host_command_interpreter.sv
`timescale 1ns/1ns
module lcd_host_command_interpreter (
    // Clock and reset
    input  wire logic                   i_core_clk,
    input  wire logic                   i_rst,
    // Host write port
    input  wire logic                   i_host_wr,
    input  wire lcd_cmd_pkg::host_req_s i_host_req,
    input  wire logic [15:0]            i_line_pitch,
    output logic                        o_host_busy,
    output logic                        o_store_refused,
    // Register contents
    output logic [7:0]                  o_display_enable,
    output logic [7:0]                  o_block_attribute_flash,
    output logic [7:0]                  o_cursor_width_cfg,
    output logic [7:0]                  o_cursor_height_style,
    output logic [7:0]                  o_cursor_step_setting,
    output logic [7:0]                  o_layer_combine_cfg,
    output logic [7:0]                  o_cursor_addr_low,
    output logic [7:0]                  o_cursor_addr_high,
    // Decoded fields
    output logic                        o_screen_on,
    output logic [1:0]                  o_cursor_flash_rate,
    output logic [1:0]                  o_first_block_attr,
    output logic [1:0]                  o_second_fourth_block_attr,
    output logic [1:0]                  o_third_block_attr,
    output logic [1:0]                  o_layer_combine_method,
    output logic                        o_first_block_text_select,
    output logic                        o_third_block_text_select,
    output logic [3:0]                  o_cursor_width,
    output logic [3:0]                  o_cursor_height,
    output logic                        o_cursor_style_select,
    // Display memory write stream
    output logic                        o_mem_valid,
    output lcd_cmd_pkg::mem_word_s      o_mem_word,
    input  wire logic                   i_mem_ready
);
    import lcd_cmd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Cursor stepping

    function automatic logic [15:0] step_addr(input logic [15:0] addr,
                                              input logic [1:0]  dir,
                                              input logic [15:0] pitch);
        logic [15:0] res;
        res = addr;
        unique case (dir)
            STEP_RIGHT: res = addr + 16'h0001;
            STEP_LEFT:  res = addr - 16'h0001;
            STEP_UP:    res = addr - pitch;
            STEP_DOWN:  res = addr + pitch;
        endcase
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    cmd_state_e  state;
    cmd_state_e  next_state;
    logic [1:0]  param_idx;
    logic [7:0]  display_enable;
    logic [7:0]  block_attribute_flash;
    logic [7:0]  cursor_width_cfg;
    logic [7:0]  cursor_height_style;
    logic [7:0]  cursor_step_setting;
    logic [7:0]  layer_combine_cfg;
    logic [15:0] cursor_addr;
    logic        store_refused;
    logic        buf_full;
    logic [7:0]  last_data;
    logic        last_wr;

    ////////////////////////////////////////////////////////////////////////////
    // Host write decoding

    wire [7:0] host_data   = i_host_req.data;
    wire       take_cmd    = i_host_wr & i_host_req.is_cmd;
    wire       take_param  = i_host_wr & ~i_host_req.is_cmd;
    wire       is_off      = host_data == CMD_SCREEN_OFF;
    wire       is_on       = host_data == CMD_SCREEN_ON;
    wire       is_step     = (host_data & CMD_STEP_MASK) == CMD_STEP_BASE;
    wire       first_param = param_idx == 2'h0;
    wire       second_param = param_idx == 2'h1;

    wire wr_screen_param = take_param & (state == ST_SCREEN_ENABLE) & first_param;
    wire wr_layer_param  = take_param & (state == ST_LAYER_COMBINE) & first_param;
    wire wr_cursor_low   = take_param & (state == ST_CURSOR_LOAD) & first_param;
    wire wr_cursor_high  = take_param & (state == ST_CURSOR_LOAD) & second_param;
    wire wr_width        = take_param & (state == ST_CURSOR_SHAPE) & first_param;
    wire wr_height       = take_param & (state == ST_CURSOR_SHAPE) & second_param;
    wire store_attempt   = take_param & (state == ST_MEMORY_STORE);
    // A full buffer refuses the byte; cursor stays put so host can resend
    wire store_byte      = store_attempt & ~buf_full;
    wire store_reject    = store_attempt & buf_full;

    ////////////////////////////////////////////////////////////////////////////
    // Command state

    always_comb begin
        next_state = state;
        if (take_cmd) begin
            unique case (host_data)
                CMD_SCREEN_OFF,
                CMD_SCREEN_ON:     next_state = ST_SCREEN_ENABLE;
                CMD_LAYER_COMBINE: next_state = ST_LAYER_COMBINE;
                CMD_CURSOR_LOAD:   next_state = ST_CURSOR_LOAD;
                CMD_CURSOR_SHAPE:  next_state = ST_CURSOR_SHAPE;
                CMD_MEMORY_STORE:  next_state = ST_MEMORY_STORE;
                // Step and unknown codes take no parameters
                default:           next_state = ST_IDLE;
            endcase
        end
    end

    // Saturates so stray extra parameters never wrap onto a used slot
    wire [1:0] next_param_idx = take_cmd ? 2'h0 :
                                (take_param && param_idx != 2'h3) ? param_idx + 2'h1 :
                                param_idx;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state     <= ST_IDLE;
            param_idx <= 2'h0;
        end else begin
            state     <= next_state;
            param_idx <= next_param_idx;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register updates

    wire [7:0] next_display_enable =
        (take_cmd && is_off) ? RST_REG_BYTE :
        (take_cmd && is_on)  ? 8'h01 << SCREEN_ON_BIT :
        display_enable;

    // Flash and block attribute fields share the one parameter byte
    wire [7:0] next_block_attribute_flash =
        wr_screen_param ? host_data : block_attribute_flash;

    wire [7:0] next_layer_combine_cfg =
        wr_layer_param ? host_data : layer_combine_cfg;

    wire [7:0] next_cursor_width_cfg =
        wr_width ? {4'h0, host_data[CURSOR_SIZE_MSB:0]} : cursor_width_cfg;

    wire [7:0] next_cursor_height_style =
        wr_height ? {host_data[CURSOR_STYLE_BIT], 3'h0,
                     host_data[CURSOR_SIZE_MSB:0]} : cursor_height_style;

    wire [7:0] next_cursor_step_setting =
        (take_cmd && is_step) ? {6'h00, host_data[1:0]} : cursor_step_setting;

    wire [15:0] stepped_addr = step_addr(cursor_addr, cursor_step_setting[1:0],
                                         i_line_pitch);

    wire [15:0] next_cursor_addr =
        wr_cursor_low  ? {cursor_addr[15:8], host_data} :
        wr_cursor_high ? {host_data, cursor_addr[7:0]} :
        store_byte     ? stepped_addr :
        cursor_addr;

    // Sticky until the next command; a refusal in that cycle cannot occur
    wire next_store_refused = store_reject ? 1'b1 :
                              take_cmd     ? 1'b0 :
                              store_refused;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            display_enable        <= RST_REG_BYTE;
            block_attribute_flash <= RST_REG_BYTE;
            layer_combine_cfg     <= RST_REG_BYTE;
            cursor_width_cfg      <= RST_REG_BYTE;
            cursor_height_style   <= RST_REG_BYTE;
            cursor_step_setting   <= RST_REG_BYTE;
        end else begin
            display_enable        <= next_display_enable;
            block_attribute_flash <= next_block_attribute_flash;
            layer_combine_cfg     <= next_layer_combine_cfg;
            cursor_width_cfg      <= next_cursor_width_cfg;
            cursor_height_style   <= next_cursor_height_style;
            cursor_step_setting   <= next_cursor_step_setting;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cursor_addr   <= RST_CURSOR_ADDR;
            store_refused <= 1'b0;
        end else begin
            cursor_addr   <= next_cursor_addr;
            store_refused <= next_store_refused;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Display memory path

    wire mem_word_s store_word = '{addr: cursor_addr, data: host_data};

    word_skid_buffer u_store_buffer (
        .i_core_clk  (i_core_clk),
        .i_rst       (i_rst),
        .i_in_valid  (store_byte),
        .i_in_word   (store_word),
        .o_in_full   (buf_full),
        .o_out_valid (o_mem_valid),
        .o_out_word  (o_mem_word),
        .i_out_ready (i_mem_ready)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign o_host_busy                = buf_full;
    assign o_store_refused            = store_refused;
    assign o_display_enable           = display_enable;
    assign o_block_attribute_flash    = block_attribute_flash;
    assign o_cursor_width_cfg         = cursor_width_cfg;
    assign o_cursor_height_style      = cursor_height_style;
    assign o_cursor_step_setting      = cursor_step_setting;
    assign o_layer_combine_cfg        = layer_combine_cfg;
    assign o_cursor_addr_low          = cursor_addr[7:0];
    assign o_cursor_addr_high         = cursor_addr[15:8];
    assign o_screen_on                = display_enable[SCREEN_ON_BIT];
    assign o_cursor_flash_rate        = block_attribute_flash[FLASH_RATE_LSB +: 2];
    assign o_first_block_attr         = block_attribute_flash[FIRST_ATTR_LSB +: 2];
    assign o_second_fourth_block_attr = block_attribute_flash[SECOND_FOURTH_ATTR_LSB +: 2];
    assign o_third_block_attr         = block_attribute_flash[THIRD_ATTR_LSB +: 2];
    assign o_layer_combine_method     = layer_combine_cfg[COMBINE_METHOD_LSB +: 2];
    assign o_first_block_text_select  = layer_combine_cfg[FIRST_TEXT_BIT];
    assign o_third_block_text_select  = layer_combine_cfg[THIRD_TEXT_BIT];
    assign o_cursor_width             = cursor_width_cfg[CURSOR_SIZE_MSB:0];
    assign o_cursor_height            = cursor_height_style[CURSOR_SIZE_MSB:0];
    assign o_cursor_style_select      = cursor_height_style[CURSOR_STYLE_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    // Helper copy of the last host byte for comparisons one cycle later
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            last_data <= RST_REG_BYTE;
            last_wr   <= 1'b0;
        end else begin
            last_data <= host_data;
            last_wr   <= i_host_wr;
        end
    end

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    screen_off_a: assert property (
        take_cmd && is_off |=> !o_screen_on && o_display_enable == 8'h00)
        else $error("screen off command did not clear enable");

    screen_on_a: assert property (
        take_cmd && is_on ##1 !take_cmd [*2] |-> o_screen_on)
        else $error("screen on command did not hold enable");

    flash_field_a: assert property (
        wr_screen_param |=> o_cursor_flash_rate == last_data[1:0])
        else $error("cursor flash rate not stored");

    block_attr_a: assert property (
        wr_screen_param |=> o_first_block_attr == last_data[3:2]
                            && o_second_fourth_block_attr == last_data[5:4]
                            && o_third_block_attr == last_data[7:6])
        else $error("block attributes not stored");

    layer_method_a: assert property (
        wr_layer_param |=> o_layer_combine_method == last_data[1:0])
        else $error("layer combine method not stored");

    text_select_a: assert property (
        wr_layer_param |=> o_first_block_text_select == last_data[2]
                           && o_third_block_text_select == last_data[3])
        else $error("text block selects not stored");

    // Host may space the two bytes apart, so each half is checked on its own
    cursor_load_a: assert property (
        wr_cursor_low |=> o_cursor_addr_low == last_data && $stable(o_cursor_addr_high))
        else $error("cursor low byte not loaded");

    cursor_high_a: assert property (
        wr_cursor_high |=> o_cursor_addr_high == last_data && $stable(o_cursor_addr_low))
        else $error("cursor high byte not loaded");

    cursor_width_a: assert property (
        wr_width |=> o_cursor_width_cfg == {4'h0, last_data[3:0]})
        else $error("cursor width not stored");

    cursor_height_a: assert property (
        wr_height |=> o_cursor_height == last_data[3:0])
        else $error("cursor height not stored");

    cursor_style_a: assert property (
        wr_height |=> o_cursor_style_select == last_data[7]
                      && o_cursor_height_style[6:4] == 3'h0)
        else $error("cursor style not stored");

    step_code_a: assert property (
        take_cmd && is_step |=> o_cursor_step_setting == {6'h00, last_data[1:0]})
        else $error("step direction not taken from command code");

    step_down_a: assert property (
        store_byte && cursor_step_setting[1:0] == STEP_DOWN |=>
            {o_cursor_addr_high, o_cursor_addr_low}
                == $past(cursor_addr) + $past(i_line_pitch))
        else $error("downward step did not add line pitch");

    store_push_a: assert property (
        store_byte |=> o_mem_valid && last_wr)
        else $error("stored byte did not reach memory stream");

    store_word_a: assert property (
        store_byte && !o_mem_valid |=> o_mem_word == {$past(cursor_addr), last_data})
        else $error("stored word has wrong address or data");

    step_right_a: assert property (
        store_byte && cursor_step_setting[1:0] == STEP_RIGHT |=>
            {o_cursor_addr_high, o_cursor_addr_low} == $past(cursor_addr) + 16'h0001)
        else $error("rightward step did not add one");

    refused_hold_a: assert property (
        store_reject |=> $stable(cursor_addr) && o_store_refused)
        else $error("refused byte moved cursor or was not flagged");

endmodule

// File: lcd_host_command_interpreter_tb.sv
`timescale 1ns/1ns
module lcd_host_command_interpreter_tb;
    import lcd_cmd_pkg::*;
    logic        i_core_clk, i_rst, i_host_wr, stall, busy, refused;
    logic        mem_valid, mem_ready, scr_on, ft, tt, style;
    host_req_s   i_host_req;
    mem_word_s   mem_word;
    logic [15:0] pitch, a;
    logic [7:0]  r09, r0a, r15, r16, r17, r18, r1c, r1d;
    logic [1:0]  fr, fa, sa, ta, meth;
    logic [3:0]  cw, ch;
    int          err_count, checks, cycles, n;

    lcd_host_command_interpreter lcd_host_command_interpreter_i (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_host_wr(i_host_wr),
        .i_host_req(i_host_req), .i_line_pitch(pitch), .o_host_busy(busy),
        .o_store_refused(refused), .o_display_enable(r09),
        .o_block_attribute_flash(r0a), .o_cursor_width_cfg(r15),
        .o_cursor_height_style(r16), .o_cursor_step_setting(r17),
        .o_layer_combine_cfg(r18), .o_cursor_addr_low(r1c), .o_cursor_addr_high(r1d),
        .o_screen_on(scr_on), .o_cursor_flash_rate(fr), .o_first_block_attr(fa),
        .o_second_fourth_block_attr(sa), .o_third_block_attr(ta),
        .o_layer_combine_method(meth), .o_first_block_text_select(ft),
        .o_third_block_text_select(tt), .o_cursor_width(cw), .o_cursor_height(ch),
        .o_cursor_style_select(style), .o_mem_valid(mem_valid), .o_mem_word(mem_word),
        .i_mem_ready(mem_ready));
    mem_sink mem_sink_i (.i_core_clk(i_core_clk), .i_stall(stall),
        .i_mem_valid(mem_valid), .i_mem_word(mem_word), .o_mem_ready(mem_ready));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        i_core_clk = 1'b0;
        forever #50 i_core_clk = ~i_core_clk;
    end

    task conclude;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Hang guard, far above the fewer than one hundred cycles the tests need
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            conclude();
        end
    end

    task chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        checks++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask

    // One byte per strobe; ends mid-cycle so register updates have landed
    task send(input logic c, input logic [7:0] d);
        @(posedge i_core_clk);
        i_host_wr <= 1'b1;
        i_host_req <= '{is_cmd: c, data: d};
        @(posedge i_core_clk);
        i_host_wr <= 1'b0;
        @(negedge i_core_clk);
    endtask

    task wait_words(input int k);
        for (int j = 0; j < 20 && mem_sink_i.got.size() < k; j++) @(negedge i_core_clk);
        chk("word count", k, mem_sink_i.got.size());
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task t_screen;
        send(1'b1, CMD_SCREEN_ON);
        send(1'b0, 8'h56);
        chk("enable on", 8'h01, r09);
        chk("flash", 2'h2, fr);
        chk("attr 0ah", 8'h56, r0a);
        send(1'b1, CMD_SCREEN_OFF);
        chk("enable off", 8'h00, {r09[7:1], scr_on});
        send(1'b0, 8'he4);
        chk("attr fields", 8'he4, {ta, sa, fa, fr});
        $display("t_screen done");
    endtask

    task t_layer;
        send(1'b1, CMD_LAYER_COMBINE);
        send(1'b0, 8'h06);
        chk("layer a", 4'h6, {tt, ft, meth});
        send(1'b1, CMD_LAYER_COMBINE);
        send(1'b0, 8'h09);
        chk("layer b", 4'h9, {tt, ft, meth});
        chk("layer_combine_cfg", 8'h09, r18);
        $display("t_layer done");
    endtask

    task t_shape;
        send(1'b1, CMD_CURSOR_SHAPE);
        send(1'b0, 8'h04);
        send(1'b0, 8'h86);
        chk("width", 12'h044, {r15, cw});
        chk("height style", 13'h1686, {style, ch, r16});
        send(1'b1, CMD_CURSOR_SHAPE);
        send(1'b0, 8'h1f);
        send(1'b0, 8'h0f);
        chk("shape b", 17'h00f0f, {style, r15, r16});
        $display("t_shape done");
    endtask

    task t_cursor;
        send(1'b1, CMD_CURSOR_LOAD);
        send(1'b0, 8'h01);
        send(1'b0, 8'h10);
        a = 16'h1001;
        chk("cursor load", a, {r1d, r1c});
        for (int i = 0; i < 4; i++) begin
            n = mem_sink_i.got.size();
            send(1'b1, CMD_STEP_BASE | 8'(i));
            chk("step reg", 8'(i), r17);
            send(1'b1, CMD_MEMORY_STORE);
            send(1'b0, 8'hff - 8'(i));
            wait_words(n + 1);
            chk("word", {a, 8'hff - 8'(i)}, mem_sink_i.got[n]);
            case (i)
                0: a = a + 16'h0001;
                1: a = a - 16'h0001;
                2: a = a - pitch;
                default: a = a + pitch;
            endcase
            chk("cursor step", a, {r1d, r1c});
        end
        $display("t_cursor done");
    endtask

    task t_stall;
        send(1'b1, CMD_STEP_BASE);
        @(posedge i_core_clk);
        stall <= 1'b1;
        send(1'b1, CMD_MEMORY_STORE);
        n = mem_sink_i.got.size();
        a = {r1d, r1c};
        send(1'b0, 8'h20);
        send(1'b0, 8'h00);
        @(negedge i_core_clk);
        chk("busy full", 1'b1, busy);
        send(1'b0, 8'hff);
        chk("refused", 1'b1, refused);
        chk("cursor kept", a + 16'h0002, {r1d, r1c});
        @(posedge i_core_clk);
        stall <= 1'b0;
        wait_words(n + 2);
        chk("drain 1", {a, 8'h20}, mem_sink_i.got[n]);
        chk("drain 2", {a + 16'h0001, 8'h00}, mem_sink_i.got[n + 1]);
        chk("busy clear", 1'b0, busy);
        chk("valid low", 1'b0, mem_valid);
        send(1'b1, CMD_STEP_BASE);
        chk("refused clear", 1'b0, refused);
        $display("t_stall done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        i_rst = 1'b1;
        i_host_wr = 1'b0;
        i_host_req = '0;
        stall = 1'b0;
        pitch = 16'h0080;
        repeat (2) @(posedge i_core_clk);
        i_rst <= 1'b0;
        @(negedge i_core_clk);
        chk("reset state", 24'h0, {r09, r1d, r1c});
        t_screen();
        t_layer();
        t_shape();
        t_cursor();
        t_stall();
        conclude();
    end
endmodule

// File: mem_sink.sv
`timescale 1ns/1ns
module mem_sink (
    // Clock
    input  wire logic                   i_core_clk,
    // Test control
    input  wire logic                   i_stall,
    // Memory stream
    input  wire logic                   i_mem_valid,
    input  wire lcd_cmd_pkg::mem_word_s i_mem_word,
    output logic                        o_mem_ready
);
    import lcd_cmd_pkg::*;
    mem_word_s got[$];
    // Ready follows stall only; a stall must not drop a held word
    assign o_mem_ready = !i_stall;
    always @(posedge i_core_clk) begin
        if (i_mem_valid && o_mem_ready) begin
            got.push_back(i_mem_word);
        end
    end
endmodule

// File: word_skid_buffer.sv
`timescale 1ns/1ns
module word_skid_buffer (
    // Clock and reset
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst,
    // Filling side
    input  wire logic                  i_in_valid,
    input  wire lcd_cmd_pkg::mem_word_s i_in_word,
    output logic                       o_in_full,
    // Draining side
    output logic                       o_out_valid,
    output lcd_cmd_pkg::mem_word_s     o_out_word,
    input  wire logic                  i_out_ready
);
    import lcd_cmd_pkg::*;

    logic      head_valid;
    logic      tail_valid;
    mem_word_s head;
    mem_word_s tail;

    wire pop  = head_valid & i_out_ready;
    // Tail slot free means one more word fits
    wire push = i_in_valid & ~tail_valid;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            head_valid <= 1'b0;
            tail_valid <= 1'b0;
            head       <= '0;
            tail       <= '0;
        end else if (pop) begin
            if (tail_valid) begin
                head       <= tail;
                tail_valid <= 1'b0;
            end else if (push) begin
                head       <= i_in_word;
            end else begin
                head_valid <= 1'b0;
            end
        end else if (push) begin
            if (!head_valid) begin
                head       <= i_in_word;
                head_valid <= 1'b1;
            end else begin
                tail       <= i_in_word;
                tail_valid <= 1'b1;
            end
        end
    end

    assign o_in_full   = tail_valid;
    assign o_out_valid = head_valid;
    assign o_out_word  = head;

endmodule
